// *** oar_consts.svh ***
// constants of the operand address resolver: register offsets, fields, ranges, timing
// assumes inclusion by bare name from the resolver top
`ifndef OAR_CONSTS_SVH
`define OAR_CONSTS_SVH

// ==========================================================
// register map (byte offsets on the plain register port)
`define OAR_ADDR_W          4
`define OAR_DATA_W          8
`define OAR_OFS_CTRL        4'h0
`define OAR_OFS_BANK_SEL    4'h1
`define OAR_OFS_CLK_CTRL    4'h2
`define OAR_OFS_STATUS      4'h3
`define OAR_OFS_LAST_BANK   4'h4

// ==========================================================
// fields and reset values
`define OAR_CTRL_BANK_EN    0
`define OAR_CTRL_EXT_MODE   1
`define OAR_CTRL_RST        2'h0
`define OAR_BANK_SEL_RST    4'h0
`define OAR_CLK_CTRL_RST    2'h0
`define OAR_STAT_ERR        0
`define OAR_STAT_SKIP_BUSY  1
`define OAR_STAT_VALID      2

// ==========================================================
// data memory banks and areas
`define OAR_BANK0           4'h0
`define OAR_BANK15          4'hf
`define OAR_BANK_MAX_LOW    4'h3
`define OAR_FMEM_HI_A       4'hb
`define OAR_FMEM_HI_B       4'hf
`define OAR_PMEM_HI         2'h3

// ==========================================================
// program memory areas
`define OAR_TOP_PAGE        3'h7
`define OAR_TOP_PAGE_END    12'hf7f
`define OAR_TADDR_MIN       8'h20
`define OAR_TADDR_MAX       8'h7f
`define OAR_REL_MIN         (-6'sd15)
`define OAR_REL_MAX_NEG     (-6'sd1)
`define OAR_REL_MIN_POS     6'sd2
`define OAR_REL_MAX         6'sd16

// ==========================================================
// machine cycle prescaler terminal counts (divisor less one) chosen by the clock control register
`define OAR_DIV0            4'h0
`define OAR_DIV1            4'h1
`define OAR_DIV2            4'h3
`define OAR_DIV3            4'hf

`endif

// *** oar_pkg.sv ***
// types shared by the operand address resolver modules
// assumes no include file; only oar_top reads oar_consts.svh
package oar_pkg;

   // ==========================================================
   // operand kinds presented with a resolve request
   typedef enum logic [4:0] {
      OAR_K_MEM_DIRECT = 5'h00,
      OAR_K_MEM_PAIR8  = 5'h01,
      OAR_K_PTR_BANKED = 5'h02,
      OAR_K_PTR_BANK0  = 5'h03,
      OAR_K_FMEM       = 5'h04,
      OAR_K_PMEM       = 5'h05,
      OAR_K_CADDR      = 5'h06,
      OAR_K_REL        = 5'h07,
      OAR_K_FADDR      = 5'h08,
      OAR_K_TADDR      = 5'h09,
      OAR_K_ADDR14     = 5'h0a,
      OAR_K_ADDR15     = 5'h0b,
      OAR_K_TABLE_ROM  = 5'h0c,
      OAR_K_IMM4       = 5'h0d,
      OAR_K_IMM8       = 5'h0e,
      OAR_K_BITPOS     = 5'h0f,
      OAR_K_PAIR       = 5'h10,
      OAR_K_PAIR_NOACC = 5'h11
   } oar_kind_t;

   // ==========================================================
   // class of the instruction that follows a skip-capable one
   typedef enum logic [2:0] {
      OAR_C_ONE_BYTE   = 3'h0,
      OAR_C_TWO_BYTE   = 3'h1,
      OAR_C_ABS_BRANCH = 3'h2,
      OAR_C_EXT_BRANCH = 3'h3,
      OAR_C_ABS_CALL   = 3'h4,
      OAR_C_EXT_CALL   = 3'h5,
      OAR_C_TABLE_CALL = 3'h6
   } oar_iclass_t;

endpackage : oar_pkg

// *** oar_skip_calc.sv ***
// fetch length and skip cost of one instruction class
// assumes a purely combinational use by the resolver top
`timescale 1ns/1ps
`default_nettype none

module oar_skip_calc
   import oar_pkg::*;
(
   input  wire oar_iclass_t iclass_in,
   input  wire logic        cond_in,
   output logic [1:0]       len_out,
   output logic [1:0]       skip_cycles_out
);

   wire three_byte;
   wire table_call;

   // ==========================================================
   // classification
   assign three_byte = (iclass_in == OAR_C_ABS_BRANCH) || (iclass_in == OAR_C_EXT_BRANCH) ||
                       (iclass_in == OAR_C_ABS_CALL) || (iclass_in == OAR_C_EXT_CALL);
   assign table_call = (iclass_in == OAR_C_TABLE_CALL);

   // table call length is irrelevant to the skip; report it as one byte
   assign len_out = three_byte ? 2'h3 :
                    (iclass_in == OAR_C_TWO_BYTE) ? 2'h2 : 2'h1;

   // ==========================================================
   // skip cost in machine cycles
   assign skip_cycles_out = !cond_in   ? 2'h0 :
                            table_call ? 2'h1 :
                            three_byte ? 2'h2 :
                                         2'h1;

endmodule : oar_skip_calc

`default_nettype wire

// *** oar_top.sv ***
// operand address resolver: data bank/address and branch target resolution, skip timing
// assumes request inputs come from core logic on MCLK_IN, so they are not synchronised
`timescale 1ns/1ps
`default_nettype none

`include "oar_consts.svh"

module oar_top
   import oar_pkg::*;
(
   input  wire logic                    MCLK_IN,
   input  wire logic                    SYS_RST_IN,
   // register port
   input  wire logic [`OAR_ADDR_W-1:0]  REG_ADDR_IN,
   input  wire logic [`OAR_DATA_W-1:0]  REG_WDATA_IN,
   input  wire logic                    REG_WR_IN,
   input  wire logic                    REG_RD_IN,
   output logic      [`OAR_DATA_W-1:0]  REG_RDATA_OUT,
   // resolve request
   input  wire logic                    REQ_VALID_IN,
   input  wire oar_kind_t               REQ_KIND_IN,
   input  wire logic [15:0]             REQ_OPERAND_IN,
   input  wire logic [14:0]             REQ_PC_IN,
   input  wire logic [7:0]              REQ_PTR_IN,
   input  wire logic [3:0]              TBL_B_IN,
   input  wire logic [3:0]              TBL_C_IN,
   input  wire logic [7:0]              TBL_LOW_IN,
   // resolve answer
   output logic                         RES_VALID_OUT,
   output logic                         RES_ERR_OUT,
   output logic [3:0]                   RES_BANK_OUT,
   output logic [11:0]                  RES_DATA_ADDR_OUT,
   output logic [14:0]                  RES_PROG_ADDR_OUT,
   output logic [7:0]                   RES_IMM_OUT,
   output logic [1:0]                   RES_BIT_POS_OUT,
   output logic [2:0]                   RES_PAIR_OUT,
   // skip request
   input  wire logic                    SKIP_REQ_IN,
   input  wire logic                    SKIP_COND_IN,
   input  wire oar_iclass_t             SKIP_NEXT_CLASS_IN,
   output logic [1:0]                   SKIP_CYCLES_OUT,
   output logic [1:0]                   SKIP_NEXT_LEN_OUT,
   output logic                         SKIP_BUSY_OUT,
   output logic                         MCYCLE_TICK_OUT
);

   // ==========================================================
   // functions
   function automatic logic bank_legal(input logic [3:0] b);
      bank_legal = (b <= `OAR_BANK_MAX_LOW) || (b == `OAR_BANK15);
   endfunction : bank_legal

   function automatic logic rel_legal(input logic signed [5:0] d);
      rel_legal = ((d >= `OAR_REL_MIN) && (d <= `OAR_REL_MAX_NEG)) ||
                  ((d >= `OAR_REL_MIN_POS) && (d <= `OAR_REL_MAX));
   endfunction : rel_legal

   function automatic logic [3:0] div_of(input logic [1:0] sel);
      div_of = (sel == 2'h0) ? `OAR_DIV0 :
               (sel == 2'h1) ? `OAR_DIV1 :
               (sel == 2'h2) ? `OAR_DIV2 : `OAR_DIV3;
   endfunction : div_of

   // ==========================================================
   // software-visible state
   logic [1:0]  ctrl_reg;
   logic [1:0]  ctrl_next;
   logic [3:0]  bank_sel_reg;
   logic [3:0]  bank_sel_next;
   logic [1:0]  cpu_clock_ctrl_reg;
   logic [1:0]  cpu_clock_ctrl_next;
   logic [`OAR_DATA_W-1:0] rdata_reg;
   logic [`OAR_DATA_W-1:0] rdata_next;

   wire bank_enable_flag;
   wire extended_addressing_mode;
   wire wr_ctrl;
   wire wr_bank;
   wire wr_clk;

   assign bank_enable_flag         = ctrl_reg[`OAR_CTRL_BANK_EN];
   assign extended_addressing_mode = ctrl_reg[`OAR_CTRL_EXT_MODE];
   assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == `OAR_OFS_CTRL);
   assign wr_bank = REG_WR_IN && (REG_ADDR_IN == `OAR_OFS_BANK_SEL);
   assign wr_clk  = REG_WR_IN && (REG_ADDR_IN == `OAR_OFS_CLK_CTRL);

   // an illegal bank number is dropped so the bank register never holds one
   assign ctrl_next           = wr_ctrl ? REG_WDATA_IN[1:0] : ctrl_reg;
   assign bank_sel_next       = (wr_bank && bank_legal(REG_WDATA_IN[3:0])) ?
                                REG_WDATA_IN[3:0] : bank_sel_reg;
   assign cpu_clock_ctrl_next = wr_clk ? REG_WDATA_IN[1:0] : cpu_clock_ctrl_reg;

   // ==========================================================
   // machine cycle timebase
   logic [3:0] presc_reg;
   logic [3:0] presc_next;
   wire        mtick;

   assign mtick      = (presc_reg >= div_of(cpu_clock_ctrl_reg));
   assign presc_next = mtick ? 4'h0 : presc_reg + 4'h1;

   // ==========================================================
   // data memory resolution
   wire [7:0]  op8;
   wire [3:0]  active_data_bank;
   wire [3:0]  direct_bank;
   wire        fmem_ok;
   wire        pmem_ok;

   assign op8              = REQ_OPERAND_IN[7:0];
   assign active_data_bank = bank_enable_flag ? bank_sel_reg : `OAR_BANK0;
   assign direct_bank      = bank_enable_flag ? bank_sel_reg :
                             (op8[7] ? `OAR_BANK15 : `OAR_BANK0);
   assign fmem_ok = (op8[7:4] == `OAR_FMEM_HI_A) || (op8[7:4] == `OAR_FMEM_HI_B);
   assign pmem_ok = (op8[7:6] == `OAR_PMEM_HI);

   // ==========================================================
   // program memory resolution
   wire signed [5:0]  rel_d;
   wire        [14:0] rel_target;
   wire        [14:0] caddr_target;
   wire        [14:0] table_target;
   wire               caddr_ok;
   wire               taddr_ok;

   assign rel_d        = REQ_OPERAND_IN[5:0];
   assign rel_target   = REQ_PC_IN + {{9{rel_d[5]}}, rel_d};
   assign caddr_target = {REQ_PC_IN[14:12], REQ_OPERAND_IN[11:0]};
   assign caddr_ok     = (!REQ_PC_IN[14] || extended_addressing_mode) &&
                         !((REQ_PC_IN[14:12] == `OAR_TOP_PAGE) &&
                           (REQ_OPERAND_IN[11:0] > `OAR_TOP_PAGE_END));
   assign taddr_ok     = (op8 >= `OAR_TADDR_MIN) && (op8 <= `OAR_TADDR_MAX) &&
                         !op8[0];
   // the top bit of B does not reach the address
   assign table_target = {TBL_B_IN[2:0], TBL_C_IN, TBL_LOW_IN};

   // ==========================================================
   // result selection
   logic        err_c;
   logic [3:0]  bank_c;
   logic [11:0] daddr_c;
   logic [14:0] paddr_c;
   logic [7:0]  imm_c;
   logic [1:0]  bitpos_c;
   logic [2:0]  pair_c;

   always_comb begin
      err_c    = 1'b0;
      bank_c   = `OAR_BANK0;
      daddr_c  = 12'h000;
      paddr_c  = 15'h0000;
      imm_c    = 8'h00;
      bitpos_c = 2'h0;
      pair_c   = 3'h0;
      unique case (REQ_KIND_IN)
         OAR_K_MEM_DIRECT: begin
            bank_c  = direct_bank;
            daddr_c = {direct_bank, op8};
         end
         OAR_K_MEM_PAIR8: begin
            bank_c  = direct_bank;
            daddr_c = {direct_bank, op8[7:1], 1'b0};
            err_c   = op8[0];
         end
         OAR_K_PTR_BANKED: begin
            bank_c  = active_data_bank;
            daddr_c = {active_data_bank, REQ_PTR_IN};
         end
         OAR_K_PTR_BANK0: begin
            bank_c  = `OAR_BANK0;
            daddr_c = {`OAR_BANK0, REQ_PTR_IN};
         end
         OAR_K_FMEM: begin
            bank_c   = `OAR_BANK15;
            daddr_c  = {`OAR_BANK15, op8};
            bitpos_c = REQ_OPERAND_IN[9:8];
            err_c    = !fmem_ok;
         end
         OAR_K_PMEM: begin
            bank_c   = `OAR_BANK15;
            daddr_c  = {`OAR_BANK15, op8};
            bitpos_c = REQ_OPERAND_IN[9:8];
            err_c    = !pmem_ok;
         end
         OAR_K_CADDR: begin
            paddr_c = caddr_target;
            err_c   = !caddr_ok;
         end
         OAR_K_REL: begin
            paddr_c = rel_target;
            err_c   = !rel_legal(rel_d);
         end
         OAR_K_FADDR: begin
            paddr_c = {4'h0, REQ_OPERAND_IN[10:0]};
         end
         OAR_K_TADDR: begin
            paddr_c = {7'h00, op8};
            err_c   = !taddr_ok;
         end
         OAR_K_ADDR14: begin
            paddr_c = {1'b0, REQ_OPERAND_IN[13:0]};
         end
         OAR_K_ADDR15: begin
            paddr_c = REQ_OPERAND_IN[14:0];
            err_c   = !extended_addressing_mode;
         end
         OAR_K_TABLE_ROM: begin
            paddr_c = table_target;
            err_c   = !extended_addressing_mode;
         end
         OAR_K_IMM4: begin
            imm_c = {4'h0, REQ_OPERAND_IN[3:0]};
         end
         OAR_K_IMM8: begin
            imm_c = op8;
         end
         OAR_K_BITPOS: begin
            bitpos_c = REQ_OPERAND_IN[1:0];
         end
         OAR_K_PAIR: begin
            pair_c = REQ_OPERAND_IN[2:0];
         end
         OAR_K_PAIR_NOACC: begin
            pair_c = REQ_OPERAND_IN[2:0];
            err_c  = (REQ_OPERAND_IN[2:0] == 3'h0);
         end
         default: begin
            err_c = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // skip timing
   logic [1:0] skip_cnt_reg;
   logic [1:0] skip_cnt_next;
   wire  [1:0] skip_cycles_c;
   wire  [1:0] skip_len_c;

   oar_skip_calc u_skip_calc (
      .iclass_in       (SKIP_NEXT_CLASS_IN),
      .cond_in         (SKIP_COND_IN),
      .len_out         (skip_len_c),
      .skip_cycles_out (skip_cycles_c)
   );

   // a new request restarts the count; the old one is assumed finished by then
   assign skip_cnt_next = SKIP_REQ_IN ? skip_cycles_c :
                          ((mtick && (skip_cnt_reg != 2'h0)) ? skip_cnt_reg - 2'h1 :
                                                               skip_cnt_reg);

   // ==========================================================
   // register read decode
   assign rdata_next =
      !REG_RD_IN                          ? 8'h00 :
      (REG_ADDR_IN == `OAR_OFS_CTRL)      ? {6'h00, ctrl_reg} :
      (REG_ADDR_IN == `OAR_OFS_BANK_SEL)  ? {4'h0, bank_sel_reg} :
      (REG_ADDR_IN == `OAR_OFS_CLK_CTRL)  ? {6'h00, cpu_clock_ctrl_reg} :
      (REG_ADDR_IN == `OAR_OFS_STATUS)    ? {5'h00, RES_VALID_OUT, SKIP_BUSY_OUT, RES_ERR_OUT} :
      (REG_ADDR_IN == `OAR_OFS_LAST_BANK) ? {4'h0, RES_BANK_OUT} : 8'h00;

   // ==========================================================
   // flip-flops
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_reg           <= `OAR_CTRL_RST;
         bank_sel_reg       <= `OAR_BANK_SEL_RST;
         cpu_clock_ctrl_reg <= `OAR_CLK_CTRL_RST;
         rdata_reg          <= 8'h00;
         presc_reg          <= 4'h0;
         skip_cnt_reg       <= 2'h0;
      end else begin
         ctrl_reg           <= ctrl_next;
         bank_sel_reg       <= bank_sel_next;
         cpu_clock_ctrl_reg <= cpu_clock_ctrl_next;
         rdata_reg          <= rdata_next;
         presc_reg          <= presc_next;
         skip_cnt_reg       <= skip_cnt_next;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         RES_VALID_OUT     <= 1'b0;
         RES_ERR_OUT       <= 1'b0;
         RES_BANK_OUT      <= `OAR_BANK0;
         RES_DATA_ADDR_OUT <= 12'h000;
         RES_PROG_ADDR_OUT <= 15'h0000;
         RES_IMM_OUT       <= 8'h00;
         RES_BIT_POS_OUT   <= 2'h0;
         RES_PAIR_OUT      <= 3'h0;
      end else begin
         RES_VALID_OUT <= REQ_VALID_IN;
         if (REQ_VALID_IN) begin
            RES_ERR_OUT       <= err_c;
            RES_BANK_OUT      <= bank_c;
            RES_DATA_ADDR_OUT <= daddr_c;
            RES_PROG_ADDR_OUT <= paddr_c;
            RES_IMM_OUT       <= imm_c;
            RES_BIT_POS_OUT   <= bitpos_c;
            RES_PAIR_OUT      <= pair_c;
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         SKIP_CYCLES_OUT   <= 2'h0;
         SKIP_NEXT_LEN_OUT <= 2'h0;
      end else if (SKIP_REQ_IN) begin
         SKIP_CYCLES_OUT   <= skip_cycles_c;
         SKIP_NEXT_LEN_OUT <= skip_len_c;
      end
   end

   assign REG_RDATA_OUT   = rdata_reg;
   assign SKIP_BUSY_OUT   = (skip_cnt_reg != 2'h0);
   assign MCYCLE_TICK_OUT = mtick;

endmodule : oar_top

`default_nettype wire

// *** oar_top_assertions.sv ***
// assertion checker of the operand address resolver, bound onto oar_top
// assumes one clock domain with the synchronous active-high reset of the top
`timescale 1ns/1ps
`default_nettype none

module oar_top_assertions
   import oar_pkg::*;
(
   input wire logic        MCLK_IN,
   input wire logic        SYS_RST_IN,
   input wire logic        REG_RD_IN,
   input wire logic        REQ_VALID_IN,
   input wire oar_kind_t   REQ_KIND_IN,
   input wire logic [15:0] REQ_OPERAND_IN,
   input wire logic [7:0]  REQ_PTR_IN,
   input wire logic        RES_ERR_OUT,
   input wire logic [3:0]  RES_BANK_OUT,
   input wire logic [11:0] RES_DATA_ADDR_OUT,
   input wire logic [14:0] RES_PROG_ADDR_OUT,
   input wire logic [7:0]  RES_IMM_OUT,
   input wire logic        SKIP_REQ_IN,
   input wire logic        SKIP_COND_IN,
   input wire oar_iclass_t SKIP_NEXT_CLASS_IN,
   input wire logic [1:0]  SKIP_CYCLES_OUT,
   input wire logic [1:0]  SKIP_NEXT_LEN_OUT
);
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   // ==========================================================
   // resolve answers, one cycle after the request
   wire logic [7:0] op_lo = REQ_OPERAND_IN[7:0];

   property p_bank0;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_PTR_BANK0 |=>
         RES_BANK_OUT == 4'h0 && RES_DATA_ADDR_OUT == {4'h0, $past(REQ_PTR_IN)};
   endproperty
   a_bank0: assert property (p_bank0) else $error("pointer access left bank 0");

   property p_fmem;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_FMEM |=> RES_DATA_ADDR_OUT == {4'hf, $past(op_lo)}
         && RES_ERR_OUT == ($past(op_lo[7:4]) != 4'hb && $past(op_lo[7:4]) != 4'hf);
   endproperty
   a_fmem: assert property (p_fmem) else $error("fast bit address wrong");

   property p_pmem;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_PMEM |=>
         RES_BANK_OUT == 4'hf && RES_ERR_OUT == ($past(op_lo[7:6]) != 2'h3);
   endproperty
   a_pmem: assert property (p_pmem) else $error("peripheral bit address wrong");

   property p_pair8;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_MEM_PAIR8 |=>
         !RES_DATA_ADDR_OUT[0] && RES_ERR_OUT == $past(op_lo[0]);
   endproperty
   a_pair8: assert property (p_pair8) else $error("pair operand not even");

   property p_rel;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_REL |=>
         RES_ERR_OUT == !($past(op_lo[5:0]) inside {[6'h02:6'h10], [6'h31:6'h3f]});
   endproperty
   a_rel: assert property (p_rel) else $error("relative range flag wrong");

   property p_faddr;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_FADDR |=>
         RES_PROG_ADDR_OUT == {4'h0, $past(REQ_OPERAND_IN[10:0])};
   endproperty
   a_faddr: assert property (p_faddr) else $error("11-bit target wrong");

   property p_taddr;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_TADDR |=> RES_ERR_OUT ==
         ($past(op_lo) < 8'h20 || $past(op_lo) > 8'h7f || $past(op_lo[0]));
   endproperty
   a_taddr: assert property (p_taddr) else $error("table entry flag wrong");

   property p_addr14;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_ADDR14 |=>
         !RES_ERR_OUT && RES_PROG_ADDR_OUT == {1'b0, $past(REQ_OPERAND_IN[13:0])};
   endproperty
   a_addr14: assert property (p_addr14) else $error("14-bit target wrong");

   property p_imm4;
      REQ_VALID_IN && REQ_KIND_IN == OAR_K_IMM4 |=> RES_IMM_OUT == {4'h0, $past(op_lo[3:0])};
   endproperty
   a_imm4: assert property (p_imm4) else $error("nibble immediate wrong");

   // ==========================================================
   // skip cost
   property p_noskip;
      SKIP_REQ_IN && !SKIP_COND_IN |=> SKIP_CYCLES_OUT == 2'h0;
   endproperty
   a_noskip: assert property (p_noskip) else $error("cost without skip");

   property p_three;
      SKIP_REQ_IN && SKIP_COND_IN && SKIP_NEXT_CLASS_IN inside {OAR_C_ABS_BRANCH,
         OAR_C_EXT_BRANCH, OAR_C_ABS_CALL, OAR_C_EXT_CALL} |=>
         SKIP_CYCLES_OUT == 2'h2 && SKIP_NEXT_LEN_OUT == 2'h3;
   endproperty
   a_three: assert property (p_three) else $error("three-byte skip wrong");

   property p_tcall;
      SKIP_REQ_IN && SKIP_COND_IN && SKIP_NEXT_CLASS_IN == OAR_C_TABLE_CALL |=>
         SKIP_CYCLES_OUT == 2'h1;
   endproperty
   a_tcall: assert property (p_tcall) else $error("table call skip wrong");

   c_rel: cover property (REQ_VALID_IN && REQ_KIND_IN == OAR_K_REL);
   c_skip: cover property (SKIP_REQ_IN && SKIP_COND_IN);
   c_read: cover property (REG_RD_IN);
endmodule : oar_top_assertions

bind oar_top oar_top_assertions i_chk (.MCLK_IN, .SYS_RST_IN, .REG_RD_IN, .REQ_VALID_IN,
   .REQ_KIND_IN, .REQ_OPERAND_IN, .REQ_PTR_IN, .RES_ERR_OUT, .RES_BANK_OUT, .RES_DATA_ADDR_OUT,
   .RES_PROG_ADDR_OUT, .RES_IMM_OUT, .SKIP_REQ_IN, .SKIP_COND_IN, .SKIP_NEXT_CLASS_IN,
   .SKIP_CYCLES_OUT, .SKIP_NEXT_LEN_OUT);

`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the operand address resolver top
// assumes design, package and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import oar_pkg::*;

   // ==========================================================
   // design connections
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  ra = 4'h0;
   logic [7:0]  wd = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        rq = 1'b0;
   oar_kind_t   kind = OAR_K_IMM4;
   logic [15:0] op = 16'h0000;
   logic [14:0] pc = 15'h0000;
   logic        sq = 1'b0;
   logic        sc = 1'b0;
   oar_iclass_t cls = OAR_C_ONE_BYTE;
   logic [7:0]  rdat, r_imm;
   logic        r_v, r_e, busy, tick;
   logic [3:0]  r_bank;
   logic [11:0] r_da;
   logic [14:0] r_pa;
   logic [1:0]  r_bit, s_cyc, s_len;
   logic [2:0]  r_pair;
   int          failures = 0;
   int          n_checks = 0;
   int          n;

   // table inputs follow the operand so table reads get real values
   oar_top i_dut (.MCLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .REQ_VALID_IN(rq),
      .REQ_KIND_IN(kind), .REQ_OPERAND_IN(op), .REQ_PC_IN(pc), .REQ_PTR_IN(op[7:0]),
      .TBL_B_IN(op[15:12]), .TBL_C_IN(op[11:8]), .TBL_LOW_IN(op[7:0]), .RES_VALID_OUT(r_v),
      .RES_ERR_OUT(r_e), .RES_BANK_OUT(r_bank), .RES_DATA_ADDR_OUT(r_da),
      .RES_PROG_ADDR_OUT(r_pa), .RES_IMM_OUT(r_imm), .RES_BIT_POS_OUT(r_bit),
      .RES_PAIR_OUT(r_pair), .SKIP_REQ_IN(sq), .SKIP_COND_IN(sc), .SKIP_NEXT_CLASS_IN(cls),
      .SKIP_CYCLES_OUT(s_cyc), .SKIP_NEXT_LEN_OUT(s_len), .SKIP_BUSY_OUT(busy),
      .MCYCLE_TICK_OUT(tick));

   always #50 clk = ~clk;

   // ==========================================================
   // access tasks
   task automatic report_and_stop();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({8'h00, rdat}, {8'h00, e});
   endtask : rreg

   // data kinds report {bit, address}; program kinds the target
   task automatic rs(input oar_kind_t k, input logic [15:0] o, input logic [14:0] p,
                     input logic e_err, input logic [15:0] e_val);
      logic [15:0] g;
      @(posedge clk);
      rq <= 1'b1;
      kind <= k;
      op <= o;
      pc <= p;
      @(posedge clk);
      rq <= 1'b0;
      #1;
      case (k)
         OAR_K_MEM_DIRECT, OAR_K_MEM_PAIR8, OAR_K_PTR_BANKED, OAR_K_PTR_BANK0, OAR_K_FMEM,
         OAR_K_PMEM: g = {|(r_bank ^ r_da[11:8]), 1'b0, r_bit, r_da};
         OAR_K_IMM4, OAR_K_IMM8: g = {8'h00, r_imm};
         OAR_K_BITPOS: g = {14'h0000, r_bit};
         OAR_K_PAIR, OAR_K_PAIR_NOACC: g = {13'h0000, r_pair};
         default: g = {1'b0, r_pa};
      endcase
      chk({14'h0000, r_v, r_e}, {14'h0000, 1'b1, e_err});
      chk(g, e_val);
   endtask : rs

   // leaves the count of busy cycles in n
   task automatic sk(input logic c, input oar_iclass_t cl, input logic [1:0] e_c,
                     input logic [1:0] e_l);
      @(posedge clk);
      sq <= 1'b1;
      sc <= c;
      cls <= cl;
      @(posedge clk);
      sq <= 1'b0;
      #1;
      chk({12'h000, s_cyc, s_len}, {12'h000, e_c, e_l});
      n = 0;
      while (busy === 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 40) begin
         failures++;
         report_and_stop();
      end
   endtask : sk

   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 3; a++) rreg(4'(a), 8'h00);
      wreg(4'hf, 8'h5a);
      rreg(4'hf, 8'h00);
      rs(OAR_K_MEM_DIRECT, 16'h0085, 15'h0000, 1'b0, 16'h0f85);
      rs(OAR_K_MEM_DIRECT, 16'h007f, 15'h0000, 1'b0, 16'h007f);
      wreg(4'h1, 8'h03);
      wreg(4'h1, 8'h05);
      rreg(4'h1, 8'h03);
      wreg(4'h0, 8'h01);
      rs(OAR_K_MEM_DIRECT, 16'h0085, 15'h0000, 1'b0, 16'h0385);
      rs(OAR_K_PTR_BANKED, 16'h0012, 15'h0000, 1'b0, 16'h0312);
      rs(OAR_K_PTR_BANK0, 16'h0034, 15'h0000, 1'b0, 16'h0034);
      rs(OAR_K_MEM_PAIR8, 16'h0085, 15'h0000, 1'b1, 16'h0384);
      rs(OAR_K_MEM_PAIR8, 16'h0022, 15'h0000, 1'b0, 16'h0322);
      rs(OAR_K_FMEM, 16'h02b5, 15'h0000, 1'b0, 16'h2fb5);
      rs(OAR_K_FMEM, 16'h00c0, 15'h0000, 1'b1, 16'h0fc0);
      rs(OAR_K_PMEM, 16'h01c3, 15'h0000, 1'b0, 16'h1fc3);
      rs(OAR_K_PMEM, 16'h00b0, 15'h0000, 1'b1, 16'h0fb0);
      rreg(4'h3, 8'h01);
      rreg(4'h4, 8'h0f);
      wreg(4'h1, 8'h0f);
      rs(OAR_K_MEM_DIRECT, 16'h0010, 15'h0000, 1'b0, 16'h0f10);
      wreg(4'h0, 8'h00);
      rs(OAR_K_CADDR, 16'h0abc, 15'h3123, 1'b0, 16'h3abc);
      rs(OAR_K_CADDR, 16'h0123, 15'h4000, 1'b1, 16'h4123);
      rs(OAR_K_ADDR14, 16'h3fff, 15'h0000, 1'b0, 16'h3fff);
      rs(OAR_K_ADDR15, 16'h7fff, 15'h0000, 1'b1, 16'h7fff);
      wreg(4'h0, 8'h02);
      rreg(4'h0, 8'h02);
      rs(OAR_K_CADDR, 16'h0123, 15'h4000, 1'b0, 16'h4123);
      rs(OAR_K_CADDR, 16'h0f7f, 15'h7000, 1'b0, 16'h7f7f);
      rs(OAR_K_CADDR, 16'h0f80, 15'h7000, 1'b1, 16'h7f80);
      rs(OAR_K_ADDR14, 16'h2001, 15'h0000, 1'b0, 16'h2001);
      rs(OAR_K_ADDR15, 16'h7fff, 15'h0000, 1'b0, 16'h7fff);
      rs(OAR_K_TABLE_ROM, 16'hfa5c, 15'h0000, 1'b0, 16'h7a5c);
      rs(OAR_K_FADDR, 16'h0fff, 15'h0000, 1'b0, 16'h07ff);
      rs(OAR_K_IMM4, 16'h00ff, 15'h0000, 1'b0, 16'h000f);
      rs(OAR_K_IMM8, 16'h01a5, 15'h0000, 1'b0, 16'h00a5);
      rs(OAR_K_BITPOS, 16'h0007, 15'h0000, 1'b0, 16'h0003);
      for (int d = -16; d <= 17; d++) begin
         rs(OAR_K_REL, 16'(d) & 16'h003f, 15'h0100,
            !((d >= -15 && d <= -1) || (d >= 2 && d <= 16)), 16'(15'h0100 + d));
      end
      for (int t = 30; t < 130; t++) begin
         rs(OAR_K_TADDR, 16'(t), 15'h0000, t < 32 || t > 127 || t[0], 16'(t));
      end
      for (int p = 0; p < 8; p++) begin
         rs(OAR_K_PAIR, 16'(p), 15'h0000, 1'b0, 16'(p));
         rs(OAR_K_PAIR_NOACC, 16'(p), 15'h0000, p == 0, 16'(p));
      end
      sk(1'b0, OAR_C_EXT_CALL, 2'h0, 2'h3);
      chk(16'(n), 16'h0000);
      for (int c = 0; c < 7; c++) begin
         sk(1'b1, oar_iclass_t'(c), (c == 6 || c < 2) ? 2'h1 : 2'h2,
            (c == 0 || c == 6) ? 2'h1 : (c == 1 ? 2'h2 : 2'h3));
         chk(16'(n), (c == 6 || c < 2) ? 16'h0001 : 16'h0002);
      end
      for (int c = 0; c < 4; c++) begin
         wreg(4'h2, 8'(c));
         rreg(4'h2, 8'(c));
         repeat (2) @(posedge clk);
         n = 0;
         repeat (32) begin
            @(posedge clk);
            #50;
            n += (tick === 1'b1);
         end
         chk(16'(n), 16'(32 >> (c == 3 ? 4 : c)));
      end
      sk(1'b1, OAR_C_ABS_BRANCH, 2'h2, 2'h3);
      chk(16'(n >= 16 && n <= 33), 16'h0001);
      report_and_stop();
   end
endmodule : tb_top

`default_nettype wire
